// ---- hdl/uep_endpoint_status.sv ----
// uep_endpoint_status: status, flags and apb registers of one usb endpoint
//
// What this block does
// RULE_01: byte count follows writes, reads, link bytes
// RULE_02: count and bank index settle with access flag
// RULE_03: allocate write recomputes config valid flag
// RULE_04: setup sets control direction; writes ignored
// RULE_05: access flag: in not full, out nonempty
// RULE_06: access flag low on stall or error
// RULE_07: active bank index 0,1,2; 3 reserved, reached only if bank count field is 3
// RULE_08: in busy count; irq when all free
// RULE_09: out busy count; irq when all busy
// RULE_10: busy count updates two cycles after release
// RULE_11: toggle 0 data0, 1 data1 per direction
// RULE_12: toggle resets data1; status resets 0x100
// RULE_13: short out packet sets short flag
// RULE_14: dma-end short in packet sets flag
// RULE_15: enabled flag raises irq; clear acknowledges
// RULE_16: stall request; flag once stall sent
// RULE_17: iso crc error flagged, packet kept
// RULE_18: overflow flagged, packet acked, tail dropped
// RULE_19: nak in and nak out flags
// RULE_20: iso in empty bank: underflow, zero-length
// RULE_21: iso out full bank: underflow, discard
// RULE_22: bit 2 setup, underflow, or zero
// RULE_23: out received flag set when bank fills
// RULE_24: clear register writes one to clear
//
// The APB interface to the registers was left to the implementer.
`default_nettype none
module uep_endpoint_status
   import uep_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pclken,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic usb_bus_reset,
   input wire uep_evt_t evt,
   output logic endpoint_interrupt,
   output logic stall_handshake,
   output logic zlp_send,
   output logic pkt_discard
);
   function automatic logic [11:0] bank_bytes(input logic [2:0] s);
      return 12'h008 << s;
   endfunction : bank_bytes

   function automatic logic fits(input logic [1:0] bk, input logic [2:0] s);
      logic [13:0] total;
      total = 14'(bank_bytes(s)) * 14'(bk + 2'h1);
      return bk != 2'h3 && bk <= UEP_MAX_BK && s <= UEP_MAX_SZ && total <= UEP_DPRAM_BYTES;
   endfunction : fits

   logic memory_allocate_bit, auto_bank_switch, ep_dir_in;
   logic [1:0] bank_count_field;
   logic [2:0] bank_size_field;
   uep_type_t ep_type;
   logic [7:0] irq_en;
   logic bank_count_irq_enable, dma_end_short_enable;
   logic [10:0] byte_counter;
   logic config_valid_flag, control_direction_flag, access_allowed_flag;
   logic [1:0] active_bank_index, occupied_bank_count, toggle_field;
   logic [7:0] flags;
   logic [UEP_REL_DLY-1:0] rel_pipe;
   logic [31:0] status_word, next_rdata;
   logic done, wr, cfg_wr, clr_wr, con_wr, rel_wr, mapped;
   logic [1:0] nbanks, next_busy, next_bank;
   logic [10:0] next_count;
   logic [11:0] size;
   logic [7:0] fset;
   logic is_ctrl, is_iso, bank_full, iso_drop, iso_empty, out_take;
   logic err, next_access_allowed_flag, new_fits, quiet, next_stall;

   // completes with one wait state: pready is registered
   assign done = psel & penable & pready;
   assign wr = done & pwrite;
   assign cfg_wr = wr && paddr == UEP_CFG_OFS;
   assign clr_wr = wr && paddr == UEP_CLR_OFS;
   assign con_wr = wr && paddr == UEP_CON_OFS;
   assign rel_wr = wr && paddr == UEP_REL_OFS && pwdata[UEP_REL_B];
   assign mapped = paddr == UEP_CFG_OFS || paddr == UEP_STA_OFS || paddr == UEP_CLR_OFS
                   || paddr == UEP_CON_OFS || paddr == UEP_REL_OFS;

   assign is_ctrl = ep_type == UEP_CTRL;
   assign is_iso = ep_type == UEP_ISO;
   assign nbanks = bank_count_field + 2'h1;
   assign size = bank_bytes(bank_size_field);
   assign bank_full = occupied_bank_count == nbanks;
   // RULE_21 full bank drops iso out
   assign iso_drop = evt.out_rx && is_iso && !ep_dir_in && bank_full;
   // RULE_20 empty bank on iso in token
   assign iso_empty = evt.in_token && is_iso && ep_dir_in && occupied_bank_count == 2'h0;
   assign out_take = evt.out_rx && !ep_dir_in && !iso_drop;
   assign new_fits = fits(pwdata[UEP_BK_LSB+:2], pwdata[UEP_SZ_LSB+:3]);

   // RULE_12 word layout, toggle resets to data1
   assign status_word = {1'b0, byte_counter, 1'b0, config_valid_flag, control_direction_flag,
                         access_allowed_flag, active_bank_index, occupied_bank_count, 2'h0,
                         toggle_field, flags};

   always_comb begin
      next_rdata = 32'h0;
      case (paddr)
         UEP_CFG_OFS: next_rdata = {19'h0, ep_type, 1'b0, auto_bank_switch, ep_dir_in, 1'b0,
                                    bank_size_field, bank_count_field, memory_allocate_bit, 1'b0};
         UEP_STA_OFS: next_rdata = status_word;
         UEP_CON_OFS: next_rdata = {12'h0, stall_handshake, 2'h0, dma_end_short_enable, 3'h0,
                                    bank_count_irq_enable, 4'h0, irq_en};
         default: next_rdata = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else if (pclken) begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         if (psel & penable & ~pready) begin
            prdata <= next_rdata;
         end
      end
   end

   // configuration and control words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         memory_allocate_bit <= 1'b0;
         bank_count_field <= 2'h0;
         bank_size_field <= 3'h0;
         ep_dir_in <= 1'b0;
         auto_bank_switch <= 1'b0;
         ep_type <= UEP_CTRL;
         irq_en <= 8'h0;
         bank_count_irq_enable <= 1'b0;
         dma_end_short_enable <= 1'b0;
      end else if (pclken) begin
         if (usb_bus_reset) begin
            memory_allocate_bit <= 1'b0;
            bank_count_field <= 2'h0;
            bank_size_field <= 3'h0;
            ep_dir_in <= 1'b0;
            auto_bank_switch <= 1'b0;
            ep_type <= UEP_CTRL;
            irq_en <= 8'h0;
            bank_count_irq_enable <= 1'b0;
            dma_end_short_enable <= 1'b0;
         end else begin
            if (cfg_wr) begin
               memory_allocate_bit <= pwdata[UEP_MEMORY_ALLOCATE_BIT_B];
               bank_count_field <= pwdata[UEP_BK_LSB+:2];
               bank_size_field <= pwdata[UEP_SZ_LSB+:3];
               ep_dir_in <= pwdata[UEP_DIR_B];
               auto_bank_switch <= pwdata[UEP_ASW_B];
               ep_type <= uep_type_t'(pwdata[UEP_TYP_LSB+:2]);
            end
            if (con_wr) begin
               irq_en <= pwdata[7:0];
               bank_count_irq_enable <= pwdata[UEP_NBKE_B];
               dma_end_short_enable <= pwdata[UEP_DMAE_B];
            end
         end
      end
   end

   // RULE_16 software request, new setup cancels it
   always_comb begin
      next_stall = stall_handshake;
      if (usb_bus_reset || evt.setup_rx) begin
         next_stall = 1'b0;
      end else if (con_wr) begin
         next_stall = pwdata[UEP_STRQ_B];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_handshake <= 1'b0;
      end else if (pclken) begin
         stall_handshake <= next_stall;
      end
   end

   // RULE_03 checked only on an allocate write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_valid_flag <= 1'b0;
      end else if (pclken) begin
         if (usb_bus_reset) begin
            config_valid_flag <= 1'b0;
         end else if (cfg_wr && pwdata[UEP_MEMORY_ALLOCATE_BIT_B]) begin
            config_valid_flag <= new_fits;
         end
      end
   end

   // RULE_04 direction of the stage after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_direction_flag <= 1'b0;
      end else if (pclken) begin
         if (usb_bus_reset) begin
            control_direction_flag <= 1'b0;
         end else if (evt.setup_rx) begin
            control_direction_flag <= evt.setup_in;
         end
      end
   end

   // RULE_10 release waits for the next bank address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rel_pipe <= '0;
      end else if (pclken) begin
         rel_pipe <= usb_bus_reset ? '0 : {rel_pipe[UEP_REL_DLY-2:0], rel_wr};
      end
   end

   always_comb begin
      next_busy = occupied_bank_count;
      next_bank = active_bank_index;
      next_count = byte_counter;
      // RULE_08 in: released banks busy, sent frees
      if (ep_dir_in) begin
         if (rel_pipe[UEP_REL_DLY-1] && !bank_full) begin
            next_busy = next_busy + 2'h1;
         end
         if (evt.in_sent && occupied_bank_count != 2'h0) begin
            next_busy = next_busy - 2'h1;
         end
      // RULE_09 out: received banks busy, release frees
      end else begin
         if (out_take && !bank_full) begin
            next_busy = next_busy + 2'h1;
         end
         if (rel_pipe[UEP_REL_DLY-1] && occupied_bank_count != 2'h0) begin
            next_busy = next_busy - 2'h1;
         end
      end
      // RULE_07 index wraps at bank count, reaching 3 only if that field is 3
      if (rel_pipe[UEP_REL_DLY-1] && !is_ctrl) begin
         next_bank = (active_bank_index >= bank_count_field) ? 2'h0 : active_bank_index + 2'h1;
      end
      // RULE_01 in: software adds, link drains
      if (ep_dir_in) begin
         next_count = next_count + 11'(evt.sw_wr) - 11'(evt.link_byte && byte_counter != 11'h0);
      // RULE_18 bytes past bank size not stored
      end else begin
         next_count = next_count + 11'(evt.link_byte && 12'(byte_counter) < size)
                      - 11'(evt.sw_rd && byte_counter != 11'h0);
      end
   end

   // RULE_06 stall or error blocks access
   // coming flags and stall too, so access never lags them by a cycle
   assign err = flags[UEP_F_OVER] || fset[UEP_F_OVER] || (is_iso && (flags[UEP_F_STALL] || fset[UEP_F_STALL]));
   // RULE_05 judged on the coming bank state
   assign next_access_allowed_flag = !is_ctrl && !next_stall && !err
                       && (ep_dir_in ? (next_busy < nbanks && 12'(next_count) < size)
                                     : (next_busy != 2'h0 && next_count != 11'h0));

   // RULE_02 all settle together; none is a poll flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         occupied_bank_count <= 2'h0;
         active_bank_index <= 2'h0;
         byte_counter <= 11'h0;
         access_allowed_flag <= 1'b0;
      end else if (pclken) begin
         if (usb_bus_reset) begin
            occupied_bank_count <= 2'h0;
            active_bank_index <= 2'h0;
            byte_counter <= 11'h0;
            access_allowed_flag <= 1'b0;
         end else begin
            occupied_bank_count <= next_busy;
            active_bank_index <= next_bank;
            byte_counter <= next_count;
            access_allowed_flag <= next_access_allowed_flag;
         end
      end
   end

   // RULE_11 in flips per packet, out keeps last pid
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         toggle_field <= UEP_DT_RST;
      end else if (pclken) begin
         if (usb_bus_reset) begin
            toggle_field <= UEP_DT_RST;
         end else if (ep_dir_in && evt.in_sent) begin
            toggle_field <= {1'b0, ~toggle_field[0]};
         end else if (out_take) begin
            toggle_field <= {1'b0, evt.out_pid[0]};
         end
      end
   end

   always_comb begin
      fset = 8'h0;
      fset[UEP_F_TXIN] = ep_dir_in && evt.in_sent;
      // RULE_23 rises with the full bank
      fset[UEP_F_RXOUT] = out_take;
      // RULE_22 bit 2 meaning by endpoint type
      fset[UEP_F_STP] = (is_ctrl && evt.setup_rx) || iso_drop || iso_empty;
      // RULE_19 both nak answers flagged
      fset[UEP_F_NAKOUT] = evt.nak_out;
      fset[UEP_F_NAKIN] = evt.nak_in;
      // RULE_18 packet still taken
      fset[UEP_F_OVER] = out_take && evt.out_over;
      // RULE_16 stall sent; RULE_17 iso crc, data kept
      fset[UEP_F_STALL] = evt.stall_sent || (is_iso && out_take && evt.out_crc);
      // RULE_13 short out; RULE_14 dma-end short in
      fset[UEP_F_SHORT] = (!is_ctrl && out_take && evt.out_short)
                          || (!is_ctrl && ep_dir_in && evt.dma_short
                              && dma_end_short_enable && auto_bank_switch);
   end

   // RULE_24 ones clear, set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= 8'h0;
      end else if (pclken) begin
         if (usb_bus_reset) begin
            flags <= 8'h0;
         end else begin
            flags <= ((flags & ~(clr_wr ? pwdata[7:0] : 8'h0)) | fset)
                     & ~{5'h0, ep_type[1], 2'h0};
         end
      end
   end

   // RULE_15 enabled flags and busy-count events
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         endpoint_interrupt <= 1'b0;
         zlp_send <= 1'b0;
         pkt_discard <= 1'b0;
      end else if (pclken) begin
         endpoint_interrupt <= !usb_bus_reset && ((|(flags & irq_en)) || (bank_count_irq_enable
                               && (ep_dir_in ? occupied_bank_count == 2'h0 : bank_full)));
         zlp_send <= !usb_bus_reset && iso_empty;
         pkt_discard <= !usb_bus_reset && iso_drop;
      end
   end

   // checks
   assign quiet = pclken && !usb_bus_reset && !evt.in_sent && presetn;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_rel;
      pclken && !usb_bus_reset && rel_wr && ep_dir_in;
   endsequence
   sequence s_rel_wait;
      s_rel ##1 quiet ##1 quiet;
   endsequence

   property p_cfg_ok;
      pclken && !usb_bus_reset && cfg_wr && pwdata[UEP_MEMORY_ALLOCATE_BIT_B] |=> config_valid_flag == $past(new_fits);
   endproperty
   a_cfg_ok: assert property (p_cfg_ok) else $error("config valid flag wrong"); // RULE_03

   property p_ctrl_dir;
      pclken && !usb_bus_reset && evt.setup_rx |=> control_direction_flag == $past(evt.setup_in);
   endproperty
   a_ctrl_dir: assert property (p_ctrl_dir) else $error("control direction wrong"); // RULE_04

   property p_rw_stall;
      stall_handshake |-> !access_allowed_flag;
   endproperty
   a_rw_stall: assert property (p_rw_stall) else $error("access allowed under stall"); // RULE_06

   property p_rel_lat;
      s_rel_wait |=> occupied_bank_count == $past(occupied_bank_count, 2) + 2'h1
                     || $past(occupied_bank_count, 2) == nbanks;
   endproperty
   a_rel_lat: assert property (p_rel_lat) else $error("busy count not updated on time"); // RULE_10

   property p_toggle_in;
      pclken && !usb_bus_reset && ep_dir_in && evt.in_sent |=> toggle_field == {1'b0, ~$past(toggle_field[0])};
   endproperty
   a_toggle_in: assert property (p_toggle_in) else $error("in toggle not flipped"); // RULE_11

   property p_bus_reset;
      pclken && usb_bus_reset |=> status_word == UEP_STA_RST;
   endproperty
   a_bus_reset: assert property (p_bus_reset) else $error("status not at reset value"); // RULE_12

   property p_irq;
      pclken && !usb_bus_reset && |(flags & irq_en) |=> endpoint_interrupt;
   endproperty
   a_irq: assert property (p_irq) else $error("enabled flag gave no interrupt"); // RULE_15

   property p_nak_in;
      pclken && !usb_bus_reset && evt.nak_in |=> flags[UEP_F_NAKIN];
   endproperty
   a_nak_in: assert property (p_nak_in) else $error("nak in flag lost"); // RULE_19

   property p_iso_drop;
      pclken && !usb_bus_reset && iso_drop |=> pkt_discard && flags[UEP_F_STP]
                                              && occupied_bank_count == $past(occupied_bank_count);
   endproperty
   a_iso_drop: assert property (p_iso_drop) else $error("full iso bank not protected"); // RULE_21

   property p_clear;
      pclken && !usb_bus_reset && clr_wr && pwdata[UEP_F_NAKOUT] && !evt.nak_out |=> !flags[UEP_F_NAKOUT];
   endproperty
   a_clear: assert property (p_clear) else $error("clear write ignored"); // RULE_24
endmodule : uep_endpoint_status
`default_nettype wire

// ---- include/uep_pkg.sv ----
// uep_pkg: offsets, fields, resets and types of the endpoint status logic
`default_nettype none
package uep_pkg;
   localparam logic [11:0] UEP_CFG_OFS = 12'h100;
   localparam logic [11:0] UEP_STA_OFS = 12'h130;
   localparam logic [11:0] UEP_CLR_OFS = 12'h160;
   localparam logic [11:0] UEP_CON_OFS = 12'h1c0;
   localparam logic [11:0] UEP_REL_OFS = 12'h1f0;
   localparam logic [31:0] UEP_STA_RST = 32'h00000100;
   localparam logic [1:0] UEP_DT_RST = 2'h1;
   // configuration word fields
   localparam int UEP_MEMORY_ALLOCATE_BIT_B = 1;
   localparam int UEP_BK_LSB = 2;
   localparam int UEP_SZ_LSB = 4;
   localparam int UEP_DIR_B = 8;
   localparam int UEP_ASW_B = 9;
   localparam int UEP_TYP_LSB = 11;
   // control word and release word fields
   localparam int UEP_NBKE_B = 12;
   localparam int UEP_DMAE_B = 16;
   localparam int UEP_STRQ_B = 19;
   localparam int UEP_REL_B = 14;
   // event flag positions
   localparam int UEP_F_TXIN = 0;
   localparam int UEP_F_RXOUT = 1;
   localparam int UEP_F_STP = 2;
   localparam int UEP_F_NAKOUT = 3;
   localparam int UEP_F_NAKIN = 4;
   localparam int UEP_F_OVER = 5;
   localparam int UEP_F_STALL = 6;
   localparam int UEP_F_SHORT = 7;
   // endpoint limits, shared memory size and release delay
   localparam logic [1:0] UEP_MAX_BK = 2'h1;
   localparam logic [2:0] UEP_MAX_SZ = 3'h6;
   localparam logic [13:0] UEP_DPRAM_BYTES = 14'h0400;
   localparam int UEP_REL_DLY = 2;

   typedef enum logic [1:0] {
      UEP_CTRL = 2'b00,
      UEP_ISO = 2'b01,
      UEP_BULK = 2'b10,
      UEP_INTR = 2'b11
   } uep_type_t;

   // one-cycle event pulses from the packet engine and the fifo port
   typedef struct packed {
      logic sw_wr;
      logic sw_rd;
      logic link_byte;
      logic setup_rx;
      logic setup_in;
      logic in_token;
      logic in_sent;
      logic out_rx;
      logic out_short;
      logic out_over;
      logic out_crc;
      logic [1:0] out_pid;
      logic nak_in;
      logic nak_out;
      logic stall_sent;
      logic dma_short;
   } uep_evt_t;
endpackage : uep_pkg
`default_nettype wire

// ---- verif/uep_host_model.sv ----
// uep_host_model: packet-engine stand-in that drives endpoint events
`default_nettype none
module uep_host_model
   import uep_pkg::*;
(
   input wire logic pclk,
   input wire logic stall_handshake,
   input wire logic zlp_send,
   input wire logic pkt_discard,
   output var uep_evt_t evt
);
   timeunit 1ns;
   timeprecision 1ps;
   int n_zlp = 0;
   int n_drop = 0;
   initial evt = '0;
   // each event is one pulse with a quiet cycle after it
   task automatic ev(input uep_evt_t e, input int n = 1);
      repeat (n) begin
         @(posedge pclk);
         evt <= e;
         @(posedge pclk);
         evt <= '0;
      end
   endtask : ev
   // host IN token; a stall handshake goes back only while one is requested
   task automatic in_req();
      ev(uep_evt_t'{in_token: 1'b1, default: '0});
      if (stall_handshake === 1'b1) begin
         ev(uep_evt_t'{stall_sent: 1'b1, default: '0});
      end
   endtask : in_req
   always @(posedge pclk) begin
      if (zlp_send === 1'b1) n_zlp++;
      if (pkt_discard === 1'b1) n_drop++;
   end
endmodule : uep_host_model
`default_nettype wire

// ---- verif/usb_endpoint_status_logic_test.sv ----
// usb_endpoint_status_logic_test: self-checking bench for the endpoint status block
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module usb_endpoint_status_logic_test
   import uep_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic pclken = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic usb_bus_reset = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, rerr, endpoint_interrupt, stall_handshake, zlp_send, pkt_discard;
   uep_evt_t evt;
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0;

   always #2 pclk = ~pclk;

   uep_endpoint_status i_dut (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .usb_bus_reset(usb_bus_reset), .evt(evt),
      .endpoint_interrupt(endpoint_interrupt), .stall_handshake(stall_handshake),
      .zlp_send(zlp_send), .pkt_discard(pkt_discard));

   uep_host_model i_host (.pclk(pclk), .stall_handshake(stall_handshake), .zlp_send(zlp_send),
      .pkt_discard(pkt_discard), .evt(evt));

   task automatic print_verdict();
      $display("errors %0d, checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   // a hang would otherwise never reach the report
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic sta();
      apb(1'b0, UEP_STA_OFS, 32'h0);
   endtask : sta

   task automatic cfg(input uep_type_t t, input logic d, input logic [1:0] bk, input logic [2:0] sz);
      apb(1'b1, UEP_CFG_OFS, (32'(t) << UEP_TYP_LSB) | (32'(d) << UEP_DIR_B) | (32'(bk) << UEP_BK_LSB)
         | (32'(sz) << UEP_SZ_LSB) | (32'h1 << UEP_MEMORY_ALLOCATE_BIT_B));
   endtask : cfg

   task automatic bus_reset();
      @(posedge pclk);
      usb_bus_reset <= 1'b1;
      @(posedge pclk);
      usb_bus_reset <= 1'b0;
      sta();
      `CHK(rd, UEP_STA_RST)
   endtask : bus_reset

   task automatic t_regs();
      sta();
      `CHK(rd, UEP_STA_RST)
      `CHK(rd[9:8], UEP_DT_RST)
      apb(1'b1, UEP_STA_OFS, 32'hffffffff);
      sta();
      `CHK(rd, UEP_STA_RST)
      apb(1'b0, 12'hffc, 32'h0);
      `CHK({rerr, rd}, {1'b1, 32'h0})
      apb(1'b0, UEP_CLR_OFS, 32'h0);
      `CHK({rerr, rd}, {1'b0, 32'h0})
   endtask : t_regs

   task automatic t_memory_allocate_bit();
      cfg(UEP_BULK, 1'b1, 2'h1, 3'h6);
      sta();
      `CHK(rd[18], 1'b1)
      cfg(UEP_BULK, 1'b1, 2'h1, 3'h7);
      sta();
      `CHK(rd[18], 1'b0)
      cfg(UEP_BULK, 1'b1, 2'h2, 3'h0);
      sta();
      `CHK(rd[18], 1'b0)
   endtask : t_memory_allocate_bit

   task automatic t_in();
      bus_reset();
      cfg(UEP_BULK, 1'b1, 2'h1, 3'h0);
      apb(1'b1, UEP_CON_OFS, 32'h1 << UEP_NBKE_B);
      sta();
      `CHK({rd[16], rd[13:12], endpoint_interrupt}, {1'b1, 2'h0, 1'b1})
      i_host.ev(uep_evt_t'{sw_wr: 1'b1, default: '0}, 8);
      sta();
      `CHK({rd[30:20], rd[16]}, {11'h008, 1'b0})
      i_host.ev(uep_evt_t'{link_byte: 1'b1, default: '0});
      i_host.ev(uep_evt_t'{in_sent: 1'b1, default: '0});
      i_host.ev(uep_evt_t'{in_token: 1'b1, default: '0});
      sta();
      `CHK({rd[30:20], rd[9:8], rd[2]}, {11'h007, 2'h0, 1'b0})
      apb(1'b1, UEP_REL_OFS, 32'h1 << UEP_REL_B);
      sta();
      `CHK({rd[15:14], rd[13:12], endpoint_interrupt}, {2'h1, 2'h1, 1'b0})
   endtask : t_in

   task automatic t_out();
      bus_reset();
      cfg(UEP_BULK, 1'b0, 2'h1, 3'h0);
      i_host.ev(uep_evt_t'{out_rx: 1'b1, out_over: 1'b1, default: '0});
      sta();
      `CHK({rd[5], rd[1], rd[16]}, {1'b1, 1'b1, 1'b0})
      apb(1'b1, UEP_CLR_OFS, 32'h1 << UEP_F_RXOUT);
      sta();
      `CHK({rd[5], rd[1]}, {1'b1, 1'b0})
      i_host.ev(uep_evt_t'{out_rx: 1'b1, out_short: 1'b1, out_pid: 2'h1, default: '0});
      sta();
      `CHK({rd[7], rd[1], rd[9:8]}, {1'b1, 1'b1, 2'h1})
   endtask : t_out

   task automatic t_flags();
      bus_reset();
      cfg(UEP_BULK, 1'b1, 2'h0, 3'h0);
      i_host.ev(uep_evt_t'{nak_in: 1'b1, default: '0});
      i_host.ev(uep_evt_t'{nak_out: 1'b1, default: '0});
      sta();
      `CHK({rd[4:3], endpoint_interrupt}, {2'h3, 1'b0})
      apb(1'b1, UEP_CON_OFS, 32'h1 << UEP_F_NAKIN);
      sta();
      `CHK(endpoint_interrupt, 1'b1)
      apb(1'b1, UEP_CLR_OFS, 32'h1 << UEP_F_NAKIN);
      sta();
      `CHK({rd[4:3], endpoint_interrupt}, {2'h1, 1'b0})
      // low clock enable must drop this nak pulse
      pclken <= 1'b0;
      i_host.ev(uep_evt_t'{nak_in: 1'b1, default: '0});
      pclken <= 1'b1;
      apb(1'b1, UEP_CLR_OFS, 32'h1 << UEP_F_NAKOUT);
      sta();
      `CHK(rd[4:3], 2'h0)
   endtask : t_flags

   task automatic t_stall();
      bus_reset();
      cfg(UEP_BULK, 1'b1, 2'h0, 3'h0);
      apb(1'b1, UEP_CON_OFS, (32'h1 << UEP_STRQ_B) | (32'h1 << UEP_F_STALL));
      sta();
      `CHK({stall_handshake, rd[16], rd[6]}, {1'b1, 1'b0, 1'b0})
      i_host.in_req();
      sta();
      `CHK({rd[6], endpoint_interrupt}, {1'b1, 1'b1})
   endtask : t_stall

   task automatic t_ctrl();
      bus_reset();
      cfg(UEP_CTRL, 1'b0, 2'h0, 3'h0);
      i_host.ev(uep_evt_t'{setup_rx: 1'b1, setup_in: 1'b1, default: '0});
      sta();
      `CHK({rd[17], rd[2]}, 2'h3)
      i_host.ev(uep_evt_t'{setup_rx: 1'b1, default: '0});
      sta();
      `CHK(rd[17], 1'b0)
   endtask : t_ctrl

   task automatic t_iso();
      bus_reset();
      cfg(UEP_ISO, 1'b1, 2'h0, 3'h0);
      i_host.ev(uep_evt_t'{in_token: 1'b1, default: '0});
      sta();
      `CHK(rd[2], 1'b1)
      `CHK(i_host.n_zlp, 1)
      bus_reset();
      cfg(UEP_ISO, 1'b0, 2'h0, 3'h0);
      i_host.ev(uep_evt_t'{out_rx: 1'b1, out_crc: 1'b1, default: '0});
      sta();
      `CHK({rd[6], rd[1], rd[2]}, 3'h6)
      i_host.ev(uep_evt_t'{out_rx: 1'b1, default: '0});
      sta();
      `CHK(rd[2], 1'b1)
      `CHK(i_host.n_drop, 1)
   endtask : t_iso

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_memory_allocate_bit();
      t_in();
      t_out();
      t_flags();
      t_stall();
      t_ctrl();
      t_iso();
      print_verdict();
   end
endmodule : usb_endpoint_status_logic_test
`undef CHK
`default_nettype wire
